// file: core/led_pwm_pkg.sv
// Constants, register map and carrier types of the LED switch PWM block.
// Assumes a 20 MHz aclk and an AXI4-Lite master with 32-bit data.
package led_pwm_pkg;

  localparam int          NUM_CH          = 8;
  localparam int          DUTY_W          = 8;
  localparam int          CLK_HZ          = 20000000;
  localparam int          CLK_PER_TICK    = 256;
  localparam int          FAIL_FREQ_HZ    = 5000;
  localparam int          FAIL_CYC        = CLK_HZ / FAIL_FREQ_HZ;
  localparam int          WAKE_TIME_S     = 2;
  localparam int          WAKE_CYC        = WAKE_TIME_S * CLK_HZ;
  localparam int          FAIL_CNT_W      = 16;
  localparam int          WAKE_CNT_W      = 26;
  localparam logic [7:0]  PHASE_STEP      = 8'h40;

  localparam logic [7:0]  OFF_INIT        = 8'h00;
  localparam logic [7:0]  OFF_CH0         = 8'h04;
  localparam logic [7:0]  OFF_CH_LAST     = 8'h20;
  localparam logic [7:0]  OFF_OUT_EN      = 8'h28;
  localparam logic [7:0]  OFF_IN_SEL_A    = 8'h2C;
  localparam logic [7:0]  OFF_IN_SEL_B    = 8'h30;
  localparam logic [7:0]  OFF_IN_SEL_C    = 8'h34;
  localparam logic [7:0]  OFF_GLOBAL_ONE  = 8'h38;
  localparam logic [7:0]  OFF_GLOBAL_TWO  = 8'h3C;
  localparam logic [7:0]  OFF_STATUS_SUM  = 8'h40;
  localparam logic [7:0]  OFF_STATUS_CLK  = 8'h44;

  localparam int          CH_DUTY_LSB     = 0;
  localparam int          CH_PHASE_LSB    = 9;
  localparam int          CH_SRC_LSB      = 11;
  localparam int          INIT_ALIGN_BIT  = 8;
  localparam int          CLK_FAIL_BIT    = 3;
  localparam logic [1:0]  AXI_OKAY        = 2'b00;
  localparam logic [1:0]  AXI_SLVERR      = 2'b10;
  localparam logic [7:0]  DIRECT_MASK     = 8'h77;

  typedef enum logic [1:0] {
    SRC_INDIV, SRC_GLOBAL_ONE, SRC_GLOBAL_TWO, SRC_FULL_ON
  } duty_source_type;

  typedef struct packed {
    logic [7:0] duty;
    logic       full_on;
    logic       off;
  } duty_set_type;

  typedef struct packed {
    logic [7:0] duty;
    logic [1:0] phase;
    logic [1:0] src;
  } chan_cfg_type;

  function automatic duty_set_type resolve(input chan_cfg_type cfg,
                                           input logic [1:0] gate_sel,
                                           input logic       direct_in,
                                           input logic [7:0] g_one,
                                           input logic [7:0] g_two);
    duty_set_type r;
    logic [1:0]   sel;
    r   = '{duty: 8'h00, full_on: 1'b0, off: 1'b0};
    sel = cfg.src;
    if (gate_sel != 2'b00 && !direct_in) begin
      case (gate_sel)
        2'b01:   r.duty = g_one;
        2'b10:   r.duty = g_two;
        default: r.off  = 1'b1;
      endcase
    end else begin
      case (sel)
        2'b00:   r.duty    = cfg.duty;
        2'b01:   r.duty    = g_one;
        2'b10:   r.duty    = g_two;
        default: r.full_on = 1'b1;
      endcase
    end
    return r;
  endfunction : resolve

endpackage : led_pwm_pkg

// file: core/led_pwm_timebase.sv
// Timebase edge finder and clock-loss watchdog for the PWM clock pin.
// Assumes the pin input is asynchronous to aclk.
`timescale 1ns/1ps
module led_pwm_timebase
  import led_pwm_pkg::*;
(
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic enable,
  input  wire logic pin_in,
  output logic      tick,
  output logic      fail
);

  typedef struct packed {
    logic                  s1;
    logic                  s2;
    logic                  s3;
    logic [FAIL_CNT_W-1:0] gap;
    logic                  tick;
    logic                  fail;
  } tb_state_type;

  tb_state_type st_q;
  tb_state_type st_d;

  localparam logic [FAIL_CNT_W-1:0] GAP_MAX = FAIL_CNT_W'(FAIL_CYC);

  always_comb begin
    st_d      = st_q;
    st_d.s1   = pin_in;
    st_d.s2   = st_q.s1;
    st_d.s3   = st_q.s2;
    st_d.tick = enable && st_q.s2 && !st_q.s3;
    if (!enable) begin
      st_d.gap  = '0;
      st_d.fail = 1'b0;
    end else if (st_d.tick) begin
      st_d.gap  = '0;
      st_d.fail = 1'b0;
    end else if (st_q.gap > GAP_MAX) begin
      st_d.fail = 1'b1;
    end else begin
      st_d.gap = st_q.gap + FAIL_CNT_W'(1);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign tick = st_q.tick;
  assign fail = st_q.fail;

endmodule : led_pwm_timebase

// file: core/led_switch_pwm_source_select.sv
// Eight-channel synchronous PWM with duty source selection and AXI4-Lite registers.
// Assumes pins are asynchronous and a single 20 MHz aclk.
//
// The placing of the registers and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ps
module led_switch_pwm_source_select
  import led_pwm_pkg::*;
#(
  parameter int WAKE_CYCLES = WAKE_CYC
)
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        device_enable_pin,
  input  wire logic        limp_pin,
  input  wire logic        internal_fail,
  input  wire logic [7:0]  direct_input_pin,
  input  wire logic        pwm_timebase_clock_pin_i,
  output logic             pwm_timebase_clock_pin_o,
  output logic             pwm_timebase_clock_pin_oe,
  output logic [7:0]       channel_out
);

  // How it works
  // - Pin clock gives 256 steps per period
  // - Edge gap above 5 kHz period is failure
  // - On clock failure outputs follow enable bits
  // - Failure flag latched until clock status read clears it
  // - Direct inputs ignored unless gate select set
  // - Enable high: pin is clock input
  // - Wake output high on wakeup or timer
  // - Limp high forces direct input drive; channels 3 and 7 are held low
  // - Internal fail drives outputs from inputs; channels 3 and 7 are held low
  // - Duty 00h off, FFh is 255/256
  // - Per channel phase of 0/90/180/270
  // - Align bit holds shared counter at zero
  // - Duty and source changes wait for wrap
  // - Off and full on apply at once
  // - Enable bit low holds output off unless limp or internal fail
  // - Gate select zero uses source select
  // - Duty from channel, global one, global two
  // - Gate set, input low: gate select decides; channels 3 and 7 ignore gate select
  // - Gate set, input high: source select decides
  // - Enable low is standby with wake output

  typedef struct packed {
    logic [1:0]      stby_s;
    logic [1:0]      limp_s;
    logic [1:0]      fail_s;
    logic [15:0]     din_s;
    logic [7:0]      din_last;
    logic            aw_got;
    logic            w_got;
    logic [7:0]      aw_addr;
    logic [31:0]     w_data;
    logic [3:0]      w_strb;
    logic            bvalid;
    logic [1:0]      bresp;
    logic            rvalid;
    logic [31:0]     rdata;
    logic [1:0]      rresp;
    logic            align;
    logic [NUM_CH*12-1:0] cfg;
    logic [7:0]      out_en;
    logic [15:0]     gate_sel;
    logic [7:0]      g_one;
    logic [7:0]      g_two;
    logic [NUM_CH*10-1:0] act;
    logic [7:0]      cnt;
    logic            clk_fail_flag;
    logic [WAKE_CNT_W-1:0] wake_cnt;
    logic            wake_o;
    logic            wake_oe;
    logic [7:0]      outs;
  } top_state_type;

  top_state_type st_q;
  top_state_type st_d;
  logic          tick;
  logic          tb_fail;

  // Edge finder and clock-loss watchdog
  led_pwm_timebase u_timebase (
    .aclk    (aclk),
    .aresetn (aresetn),
    .enable  (!st_q.stby_s[1]),
    .pin_in  (pwm_timebase_clock_pin_i),
    .tick    (tick),
    .fail    (tb_fail)
  );

  function automatic logic [31:0] apply_strb(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  strb);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) r[b*8 +: 8] = new_v[b*8 +: 8];
    end
    return r;
  endfunction : apply_strb

  // Channel register word to stored fields and back
  function automatic logic [31:0] cfg_to_word(input chan_cfg_type cfg);
    logic [31:0] w;
    w                    = 32'h0000_0000;
    w[CH_DUTY_LSB +: 8]  = cfg.duty;
    w[CH_PHASE_LSB +: 2] = cfg.phase;
    w[CH_SRC_LSB +: 2]   = cfg.src;
    return w;
  endfunction : cfg_to_word

  function automatic chan_cfg_type word_to_cfg(input logic [31:0] w);
    chan_cfg_type cfg;
    cfg.duty  = w[CH_DUTY_LSB +: 8];
    cfg.phase = w[CH_PHASE_LSB +: 2];
    cfg.src   = w[CH_SRC_LSB +: 2];
    return cfg;
  endfunction : word_to_cfg

  always_comb begin
    logic          enabled;
    logic          fail_mode;
    logic [7:0]    din;
    logic          wr_go;
    logic          rd_go;
    logic          clear_flag;
    logic [31:0]   rv;
    logic          hit;
    chan_cfg_type  c;
    duty_set_type  ns;
    duty_set_type  cur;
    logic [7:0]    pos;
    logic          pwm_on;
    logic          o;
    enabled    = 1'b0;
    fail_mode  = 1'b0;
    din        = 8'h00;
    wr_go      = 1'b0;
    rd_go      = 1'b0;
    clear_flag = 1'b0;
    rv         = 32'h0000_0000;
    hit        = 1'b0;
    c          = '0;
    ns         = '0;
    cur        = '0;
    pos        = 8'h00;
    pwm_on     = 1'b0;
    o          = 1'b0;
    st_d       = st_q;

    // Pin synchronisers; standby clears to active
    st_d.stby_s = {st_q.stby_s[0], !device_enable_pin};
    st_d.limp_s = {st_q.limp_s[0], limp_pin};
    st_d.fail_s = {st_q.fail_s[0], internal_fail};
    st_d.din_s  = {st_q.din_s[7:0], direct_input_pin};
    enabled     = !st_q.stby_s[1];
    fail_mode   = st_q.limp_s[1] || st_q.fail_s[1];
    din         = st_q.din_s[15:8] & DIRECT_MASK;
    st_d.din_last = din;

    // Write channel
    if (s_axi_awvalid && !st_q.aw_got) begin
      st_d.aw_got  = 1'b1;
      st_d.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !st_q.w_got) begin
      st_d.w_got  = 1'b1;
      st_d.w_data = s_axi_wdata;
      st_d.w_strb = s_axi_wstrb;
    end
    if (st_q.bvalid && s_axi_bready) st_d.bvalid = 1'b0;
    wr_go = st_q.aw_got && st_q.w_got && !st_q.bvalid;
    if (wr_go) begin
      st_d.aw_got = 1'b0;
      st_d.w_got  = 1'b0;
      st_d.bvalid = 1'b1;
      st_d.bresp  = AXI_OKAY;
      if (st_q.aw_addr == OFF_INIT) begin
        st_d.align = st_q.w_data[INIT_ALIGN_BIT] && st_q.w_strb[1];
      end else if (st_q.aw_addr >= OFF_CH0 && st_q.aw_addr <= OFF_CH_LAST
                   && st_q.aw_addr[1:0] == 2'b00) begin
        for (int i = 0; i < NUM_CH; i++) begin
          if (st_q.aw_addr == OFF_CH0 + 8'(i * 4)) begin
            st_d.cfg[i*12 +: 12] = word_to_cfg(apply_strb(cfg_to_word(st_q.cfg[i*12 +: 12]),
                                                          st_q.w_data, st_q.w_strb));
          end
        end
      end else if (st_q.aw_addr == OFF_OUT_EN) begin
        st_d.out_en = 8'(apply_strb(32'(st_q.out_en), st_q.w_data, st_q.w_strb));
      end else if (st_q.aw_addr == OFF_IN_SEL_A) begin
        st_d.gate_sel[5:0] = 6'(apply_strb(32'(st_q.gate_sel[5:0]),
                                           st_q.w_data, st_q.w_strb));
      end else if (st_q.aw_addr == OFF_IN_SEL_B) begin
        st_d.gate_sel[11:6] = 6'(apply_strb(32'(st_q.gate_sel[11:6]),
                                            st_q.w_data, st_q.w_strb));
      end else if (st_q.aw_addr == OFF_IN_SEL_C) begin
        st_d.gate_sel[15:12] = 4'(apply_strb(32'(st_q.gate_sel[15:12]),
                                             st_q.w_data, st_q.w_strb));
      end else if (st_q.aw_addr == OFF_GLOBAL_ONE) begin
        st_d.g_one = 8'(apply_strb(32'(st_q.g_one), st_q.w_data, st_q.w_strb));
      end else if (st_q.aw_addr == OFF_GLOBAL_TWO) begin
        st_d.g_two = 8'(apply_strb(32'(st_q.g_two), st_q.w_data, st_q.w_strb));
      end else if (st_q.aw_addr == OFF_STATUS_SUM || st_q.aw_addr == OFF_STATUS_CLK) begin
        st_d.bresp = AXI_OKAY;
      end else begin
        st_d.bresp = AXI_SLVERR;
      end
    end

    // Read channel
    if (st_q.rvalid && s_axi_rready) st_d.rvalid = 1'b0;
    rd_go = s_axi_arvalid && !st_q.rvalid;
    if (rd_go) begin
      hit = 1'b1;
      case (s_axi_araddr)
        OFF_INIT:       rv[INIT_ALIGN_BIT] = st_q.align;
        OFF_OUT_EN:     rv[7:0]  = st_q.out_en;
        OFF_IN_SEL_A:   rv[5:0]  = st_q.gate_sel[5:0];
        OFF_IN_SEL_B:   rv[5:0]  = st_q.gate_sel[11:6];
        OFF_IN_SEL_C:   rv[3:0]  = st_q.gate_sel[15:12];
        OFF_GLOBAL_ONE: rv[7:0]  = st_q.g_one;
        OFF_GLOBAL_TWO: rv[7:0]  = st_q.g_two;
        OFF_STATUS_SUM: rv[CLK_FAIL_BIT] = st_q.clk_fail_flag;
        OFF_STATUS_CLK: begin
          rv[CLK_FAIL_BIT] = st_q.clk_fail_flag;
          clear_flag       = 1'b1;
        end
        default: begin
          hit = 1'b0;
          for (int i = 0; i < NUM_CH; i++) begin
            if (s_axi_araddr == OFF_CH0 + 8'(i * 4)) begin
              rv       = cfg_to_word(st_q.cfg[i*12 +: 12]);
              hit      = 1'b1;
            end
          end
        end
      endcase
      st_d.rvalid = 1'b1;
      st_d.rdata  = rv;
      st_d.rresp  = hit ? AXI_OKAY : AXI_SLVERR;
    end

    // Latched clock-loss flag, set wins over clear
    if (clear_flag) st_d.clk_fail_flag = 1'b0;
    if (tb_fail) st_d.clk_fail_flag = 1'b1;

    // Shared counter; align bit holds it at zero
    if (st_q.align) begin
      st_d.cnt = 8'h00;
    end else if (tick) begin
      st_d.cnt = st_q.cnt + 8'h01;
    end

    // Per channel source, phase and drive
    for (int i = 0; i < NUM_CH; i++) begin
      c   = st_q.cfg[i*12 +: 12];
      ns  = resolve(c, DIRECT_MASK[i] ? st_q.gate_sel[i*2 +: 2] : 2'b00,
                    din[i], st_q.g_one, st_q.g_two);
      cur = st_q.act[i*10 +: 10];
      if (ns.off || ns.full_on || cur.off || cur.full_on) begin
        st_d.act[i*10 +: 10] = ns;
      end else if (tick && st_q.cnt == 8'hFF) begin
        st_d.act[i*10 +: 10] = ns;
      end
      pos    = st_q.cnt - 8'(PHASE_STEP * c.phase);
      pwm_on = cur.full_on || (!cur.off && pos < cur.duty);
      if (fail_mode) begin
        o = DIRECT_MASK[i] && din[i];
      end else if (!st_q.out_en[i]) begin
        o = 1'b0;
      end else if (tb_fail || !enabled) begin
        o = 1'b1;
      end else begin
        o = pwm_on;
      end
      st_d.outs[i] = o;
    end

    // Wake pin role
    st_d.wake_oe = !enabled;
    if (enabled) begin
      st_d.wake_cnt = '0;
    end else if ((din & ~st_q.din_last) != 8'h00) begin
      st_d.wake_cnt = WAKE_CNT_W'(WAKE_CYCLES);
    end else if (st_q.wake_cnt != '0) begin
      st_d.wake_cnt = st_q.wake_cnt - WAKE_CNT_W'(1);
    end
    st_d.wake_o = !enabled && ((din != 8'h00) || (st_q.wake_cnt != '0));
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign s_axi_awready             = s_axi_awvalid && !st_q.aw_got;
  assign s_axi_wready              = s_axi_wvalid && !st_q.w_got;
  assign s_axi_bvalid              = st_q.bvalid;
  assign s_axi_bresp               = st_q.bresp;
  assign s_axi_arready             = s_axi_arvalid && !st_q.rvalid;
  assign s_axi_rvalid              = st_q.rvalid;
  assign s_axi_rdata               = st_q.rdata;
  assign s_axi_rresp               = st_q.rresp;
  assign pwm_timebase_clock_pin_o  = st_q.wake_o;
  assign pwm_timebase_clock_pin_oe = st_q.wake_oe;
  assign channel_out               = st_q.outs;

endmodule : led_switch_pwm_source_select

// file: verification/led_pwm_sva.sv
// Port checker of the LED PWM block.
// Assumes one aclk domain with synchronous active-low reset.
`timescale 1ns/1ps
module led_pwm_sva
  import led_pwm_pkg::*;
#(
  parameter int WAKE_CYCLES = WAKE_CYC
)
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0]  s_axi_wstrb,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        device_enable_pin,
  input wire logic        limp_pin,
  input wire logic        internal_fail,
  input wire logic [7:0]  direct_input_pin,
  input wire logic        pwm_timebase_clock_pin_i,
  input wire logic        pwm_timebase_clock_pin_o,
  input wire logic        pwm_timebase_clock_pin_oe,
  input wire logic [7:0]  channel_out
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence standby_s; !device_enable_pin [*5]; endsequence
  sequence active_s; device_enable_pin [*5]; endsequence
  sequence wake_s; (!device_enable_pin && (direct_input_pin & DIRECT_MASK) != 8'h00) [*6]; endsequence
  sequence limp_s; (limp_pin && device_enable_pin && $stable(direct_input_pin)) [*6]; endsequence
  sequence ifail_s;
    (internal_fail && !limp_pin && device_enable_pin && $stable(direct_input_pin)) [*6];
  endsequence
  a_aw_ready_cause: assert property (s_axi_awready |-> s_axi_awvalid)
    else $error("awready without awvalid");
  a_b_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_r_data_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_wake_drive: assert property (standby_s |-> pwm_timebase_clock_pin_oe)
    else $error("wake pin not driven in standby");
  a_clock_input: assert property (active_s |-> !pwm_timebase_clock_pin_oe)
    else $error("pin driven while active");
  a_wake_level: assert property (wake_s |-> pwm_timebase_clock_pin_o)
    else $error("wake level low with input high");
  a_limp_direct: assert property (limp_s |-> channel_out == (direct_input_pin & DIRECT_MASK))
    else $error("outputs not following inputs in limp mode");
  a_fail_direct: assert property (ifail_s |-> channel_out == (direct_input_pin & DIRECT_MASK))
    else $error("outputs not following inputs in fail mode");
endmodule : led_pwm_sva

bind led_switch_pwm_source_select led_pwm_sva #(.WAKE_CYCLES(WAKE_CYCLES)) led_pwm_sva_i (.*);

// file: verification/testbench.sv
// Self-checking bench of the LED PWM block over AXI4-Lite.
// Assumes the controller model supplies the timebase clock.
`timescale 1ns/1ps
module testbench
  import led_pwm_pkg::*;
;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, direct_input_pin, channel_out;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic        aclk, aresetn, device_enable_pin, limp_pin, internal_fail, run, mclk;
  logic        pwm_timebase_clock_pin_i, pwm_timebase_clock_pin_o, pwm_timebase_clock_pin_oe;
  int          n_errors, check_count;

  assign pwm_timebase_clock_pin_i = pwm_timebase_clock_pin_oe ? pwm_timebase_clock_pin_o : mclk;
  led_switch_pwm_source_select #(.WAKE_CYCLES(50)) led_switch_pwm_source_select_i (.*);
  ucu_model #(.HALF(500)) ucu_model_i (.run(run), .pwm_clk(mclk));

  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end

  initial begin
    repeat (90000) @(posedge aclk);
    check("run time", 32'h1, 32'h0);
    close_out();
  end

  task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : check

  task automatic close_out();
    if (n_errors == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : close_out

  task automatic wt(input int c);
    repeat (c) @(posedge aclk);
  endtask : wt

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    logic ta, tw, tb;
    logic [1:0] r;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(negedge aclk);
      ta = s_axi_awready;
      tw = s_axi_wready;
      tb = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      n++;
    end while (tb !== 1'b1 && n < 200);
    if (n >= 200) begin
      check("write wait", 32'h1, 32'h0);
      close_out();
    end
    check("bresp", {30'h0, r}, {30'h0, er});
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [1:0] er, input logic [31:0] m,
                    input logic [31:0] exp);
    int n;
    logic ta, tr;
    logic [31:0] d;
    logic [1:0] r;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(negedge aclk);
      ta = s_axi_arready;
      tr = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk);
      if (ta) s_axi_arvalid <= 1'b0;
      n++;
    end while (tr !== 1'b1 && n < 200);
    if (n >= 200) begin
      check("read wait", 32'h1, 32'h0);
      close_out();
    end
    check("rresp", {30'h0, r}, {30'h0, er});
    check("rdata", d & m, exp);
  endtask : rd

  function automatic logic [31:0] cw(input logic [1:0] s, input logic [1:0] p,
                                     input logic [7:0] d);
    return (32'(d) << CH_DUTY_LSB) | (32'(p) << CH_PHASE_LSB) | (32'(s) << CH_SRC_LSB);
  endfunction : cw

  // Counts on-steps of one channel over a full period, after 300 steps for the buffer
  task automatic duty_of(input int ch, input logic [8:0] exp);
    logic [8:0] cnt;
    cnt = 9'h000;
    repeat (300) @(negedge mclk);
    repeat (256) begin
      @(negedge mclk);
      cnt = cnt + {8'h00, channel_out[ch]};
    end
    check("duty count", {23'h0, cnt}, {23'h0, exp});
    @(posedge aclk);
  endtask : duty_of

  initial begin
    aresetn = 1'b0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, direct_input_pin} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, limp_pin, internal_fail, run} = '0;
    s_axi_wstrb = 4'hF;
    s_axi_bready = 1'b1;
    s_axi_rready = 1'b1;
    device_enable_pin = 1'b1;
    n_errors = 0;
    check_count = 0;
    wt(16);
    aresetn <= 1'b1;
    run <= 1'b1;
    wt(4);
    rd(OFF_STATUS_CLK, AXI_OKAY, 32'h8, 32'h0);
    rd(8'h48, AXI_SLVERR, 32'hFFFFFFFF, 32'h0);
    wr(8'h4C, 32'h1, AXI_SLVERR);
    direct_input_pin <= 8'hFF;
    wr(OFF_OUT_EN, 32'hFF, AXI_OKAY);
    wt(20);
    check("inputs ignored", {24'h0, channel_out}, 32'h00);
    wr(OFF_CH0, cw(2'b11, 2'b00, 8'h00), AXI_OKAY);
    wt(6);
    check("full on now", {24'h0, channel_out}, 32'h01);
    direct_input_pin <= 8'h00;
    wr(OFF_IN_SEL_A, 32'h3, AXI_OKAY);
    wt(8);
    check("gate off", {24'h0, channel_out}, 32'h00);
    direct_input_pin <= 8'h01;
    wt(8);
    check("gate pass", {24'h0, channel_out}, 32'h01);
    direct_input_pin <= 8'h00;
    wr(OFF_IN_SEL_A, 32'h1, AXI_OKAY);
    wr(OFF_GLOBAL_ONE, 32'h40, AXI_OKAY);
    duty_of(0, 9'd64);
    wr(OFF_INIT, 32'h100, AXI_OKAY);
    wt(2560);
    check("align hold", {24'h0, channel_out}, 32'h01);
    wr(OFF_GLOBAL_ONE, 32'h00, AXI_OKAY);
    wt(2560);
    check("buffered duty", {24'h0, channel_out}, 32'h01);
    rd(OFF_INIT, AXI_OKAY, 32'h100, 32'h100);
    wr(OFF_INIT, 32'h0, AXI_OKAY);
    wr(OFF_IN_SEL_A, 32'h2, AXI_OKAY);
    wr(OFF_GLOBAL_TWO, 32'hFF, AXI_OKAY);
    duty_of(0, 9'd255);
    wr(OFF_IN_SEL_A, 32'h0, AXI_OKAY);
    wr(OFF_CH0, cw(2'b00, 2'b10, 8'h80), AXI_OKAY);
    duty_of(0, 9'd128);
    wr(OFF_CH0 + 8'h04, cw(2'b00, 2'b00, 8'h80), AXI_OKAY);
    repeat (300) @(negedge mclk);
    check("phase split", {31'h0, channel_out[0] ^ channel_out[1]}, 32'h1);
    @(posedge aclk);
    wr(OFF_CH0 + 8'h04, cw(2'b11, 2'b00, 8'h00), AXI_OKAY);
    wr(OFF_CH0, cw(2'b11, 2'b00, 8'h00), AXI_OKAY);
    wr(OFF_OUT_EN, 32'hFE, AXI_OKAY);
    wt(6);
    check("enable off", {24'h0, channel_out}, 32'h02);
    wr(OFF_OUT_EN, 32'hA5, AXI_OKAY);
    run <= 1'b0;
    wt(3800);
    check("no early loss", {24'h0, channel_out}, 32'h01);
    wt(400);
    check("loss outputs", {24'h0, channel_out}, 32'hA5);
    rd(OFF_STATUS_SUM, AXI_OKAY, 32'h8, 32'h8);
    run <= 1'b1;
    wt(40);
    rd(OFF_STATUS_CLK, AXI_OKAY, 32'h8, 32'h8);
    rd(OFF_STATUS_CLK, AXI_OKAY, 32'h8, 32'h0);
    limp_pin <= 1'b1;
    direct_input_pin <= 8'h5A;
    wt(8);
    check("limp drive", {24'h0, channel_out}, 32'h52);
    limp_pin <= 1'b0;
    internal_fail <= 1'b1;
    direct_input_pin <= 8'hAF;
    wt(8);
    check("fail drive", {24'h0, channel_out}, 32'h27);
    internal_fail <= 1'b0;
    direct_input_pin <= 8'h00;
    run <= 1'b0;
    wt(40);
    device_enable_pin <= 1'b0;
    wt(8);
    check("wake enable", {31'h0, pwm_timebase_clock_pin_oe}, 32'h1);
    check("wake idle", {31'h0, pwm_timebase_clock_pin_o}, 32'h0);
    direct_input_pin <= 8'h04;
    wt(6);
    check("wake input", {31'h0, pwm_timebase_clock_pin_o}, 32'h1);
    direct_input_pin <= 8'h00;
    wt(20);
    check("wake timer", {31'h0, pwm_timebase_clock_pin_o}, 32'h1);
    wt(60);
    check("wake expiry", {31'h0, pwm_timebase_clock_pin_o}, 32'h0);
    close_out();
  end
endmodule : testbench

// file: verification/ucu_model.sv
// Controller-side model: timebase clock at 256 steps per PWM period.
// Assumes the bench starts and stops it through run.
`timescale 1ns/1ps
module ucu_model #(
  parameter int HALF = 500
)
(
  input  wire logic run,
  output logic      pwm_clk
);
  initial begin
    pwm_clk = 1'b0;
    forever begin
      #(HALF);
      pwm_clk = run ? ~pwm_clk : 1'b0;
    end
  end
endmodule : ucu_model
